// ---- design/pbcs_defs.svh ----
`ifndef PBCS_DEFS_SVH
`define PBCS_DEFS_SVH

// management register indices answered by this block
`define PBCS_REG_CTL 5'h00
`define PBCS_REG_STS 5'h01

// default management address of the copper port
`define PBCS_PHY_ADDR_RST 5'h02

// basic control word: reset value and writable bits
`define PBCS_CTL_RST 16'h1020
`define PBCS_CTL_WMASK 16'h7B3F

// control field positions
`define PBCS_CTL_LOOP_BIT 4'hE
`define PBCS_CTL_RESTART_BIT 4'h9

// basic status: fixed capability bits 15..11
`define PBCS_STS_CAPS 5'h0F

// management frame constants
`define PBCS_PREAMBLE_ONES 6'h20
`define PBCS_OP_READ 2'h2
`define PBCS_OP_WRITE 2'h1
`define PBCS_HDR_LAST 5'h0B
`define PBCS_DATA_BITS 5'h10

`endif

// ---- design/pbcs_pkg.sv ----
package pbcs_pkg;

    // basic control word, bit 15 down to bit 0
    typedef struct packed {
        logic soft_reset;
        logic loopback;
        logic force_100;
        logic autoneg_on;
        logic power_down;
        logic isolate;
        logic autoneg_restart;
        logic force_full;
        logic collision_test;
        logic reserved6;
        logic crossover_algorithm_select;
        logic force_straight_pinout;
        logic crossover_detect_off;
        logic far_end_fault_off;
        logic transmit_off;
        logic led_off;
    } pbcs_ctl_s;

    // serial frame states, gray along preamble-start-header-turnaround-read data
    typedef enum logic [2:0] {
        PBCS_PRE = 3'h0,
        PBCS_START = 3'h1,
        PBCS_HDR = 3'h3,
        PBCS_TA = 3'h2,
        PBCS_RDATA = 3'h6,
        PBCS_WDATA = 3'h7
    } pbcs_state_e;

endpackage

// ---- design/pbcs_phy_regs.sv ----
`timescale 1ns/1ps
`include "pbcs_defs.svh"
// Function
// - basic control word at register zero
// - loopback bit, port 1 wrap path
// - loopback bit, port 2 wrap path
// - bit 12 autoneg enable, default one
// - writing bit 9 restarts autonegotiation
// - bit 5 selects crossover algorithm, default one
// - bit 4 forces straight-through pinout
// - bit 3 disables automatic crossover detection
// - bit 2 disables far-end fault detection
// - bit 1 stops the transmitter
// - read-only basic status at register one
// - status bit 15 reads zero
// - status bit 14 reads one
// - status bit 13 reads one
// - status bit 12 reads one
// - answer at management address two by default
// - management address reprogrammable from global register
module pbcs_phy_regs
    import pbcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic phy_addr_load,
    input wire logic [4:0] phy_addr_cfg,
    input wire logic mirror_we,
    input wire logic [15:0] mirror_wdata,
    input wire logic loop_sel_port2,
    input wire logic link_up,
    input wire logic an_done,
    input wire logic far_end_fault,
    output pbcs_ctl_s ctl,
    output logic autoneg_restart_pulse,
    output logic loop_port1_on,
    output logic loop_port2_on
);

    logic mdc_s1_r;
    logic mdc_s2_r;
    logic mdc_s3_r;
    logic mdio_s1_r;
    logic mdio_s2_r;
    logic mdc_rise;
    logic bit_in;
    pbcs_state_e state_r;
    logic [5:0] ones_r;
    logic [4:0] cnt_r;
    logic [10:0] hdr_r;
    logic [11:0] hdr_full;
    logic is_read_r;
    logic [4:0] reg_r;
    logic [15:0] rd_sh_r;
    logic [15:0] wd_sh_r;
    logic commit_r;
    logic [15:0] commit_data_r;
    logic [4:0] phy_addr_r;
    pbcs_ctl_s ctl_r;
    logic [15:0] sts;
    logic [15:0] rd_val;
    logic hdr_bit;
    logic hdr_end;
    logic hdr_hit;
    logic ta_read;
    logic rd_bit;
    logic rd_last;
    logic wr_bit;

    // both pins cross in through two flops; mdc takes a third flop so its rising edge can be found from stages two and three
    always_ff @(posedge clk) begin
        if (rst) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_s3_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
        end else begin
            mdc_s1_r <= mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_s3_r <= mdc_s2_r;
            mdio_s1_r <= mdio_in;
            mdio_s2_r <= mdio_s1_r;
        end
    end

    assign mdc_rise = mdc_s2_r & ~mdc_s3_r;
    assign bit_in = mdio_s2_r;
    assign hdr_full = {hdr_r, bit_in};

    // frame position strobes, one cycle wide, shared by the capture blocks
    assign hdr_bit = mdc_rise && (state_r == PBCS_HDR);
    assign hdr_end = hdr_bit && (cnt_r == `PBCS_HDR_LAST);
    // only our own address with a read or write opcode is answered
    assign hdr_hit = (hdr_full[9:5] == phy_addr_r) &&
                     (hdr_full[11:10] == `PBCS_OP_READ ||
                      hdr_full[11:10] == `PBCS_OP_WRITE);
    assign ta_read = mdc_rise && (state_r == PBCS_TA) && is_read_r;
    assign rd_bit = mdc_rise && (state_r == PBCS_RDATA);
    assign rd_last = rd_bit && (cnt_r == `PBCS_DATA_BITS);
    assign wr_bit = mdc_rise && (state_r == PBCS_WDATA);

    // address the port answers to; the global register may move it
    always_ff @(posedge clk) begin
        if (rst) begin
            phy_addr_r <= `PBCS_PHY_ADDR_RST;
        end else if (phy_addr_load) begin
            phy_addr_r <= phy_addr_cfg;
        end
    end

    // status word: capability bits are constants, bits 5..2 are live state, the rest reads zero
    always_comb begin
        sts = 16'h0000;
        sts[15:11] = `PBCS_STS_CAPS;
        sts[5] = an_done;
        sts[4] = far_end_fault;
        sts[3] = ctl_r.autoneg_on;
        sts[2] = link_up;
    end

    // registers outside this block read as zero here
    always_comb begin
        if (hdr_full[4:0] == `PBCS_REG_CTL) begin
            rd_val = ctl_r;
        end else if (hdr_full[4:0] == `PBCS_REG_STS) begin
            rd_val = sts;
        end else begin
            rd_val = 16'h0000;
        end
    end

    // header capture: shift every header bit, keep the fields of the last one
    always_ff @(posedge clk) begin
        if (rst) begin
            hdr_r <= 11'h000;
            is_read_r <= 1'b0;
            reg_r <= 5'h00;
        end else if (hdr_bit) begin
            hdr_r <= hdr_full[10:0];
            if (hdr_end) begin
                reg_r <= hdr_full[4:0];
                is_read_r <= (hdr_full[11:10] == `PBCS_OP_READ);
            end
        end
    end

    // read answer: the word is latched at the end of the header so a later
    // write cannot tear it; data is launched just after the management edge
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_sh_r <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (hdr_end) begin
            rd_sh_r <= rd_val;
        end else if (ta_read) begin
            mdio_oe <= 1'b1; // second turnaround bit driven low
            mdio_out <= 1'b0;
        end else if (rd_last) begin
            mdio_oe <= 1'b0;
            mdio_out <= 1'b0;
        end else if (rd_bit) begin
            mdio_out <= rd_sh_r[15];
            rd_sh_r <= {rd_sh_r[14:0], 1'b0};
        end
    end

    // write capture; nothing commits before the sixteenth data bit
    always_ff @(posedge clk) begin
        if (rst) begin
            wd_sh_r <= 16'h0000;
            commit_r <= 1'b0;
            commit_data_r <= 16'h0000;
        end else begin
            commit_r <= 1'b0;
            if (wr_bit) begin
                wd_sh_r <= {wd_sh_r[14:0], bit_in};
                if (cnt_r == `PBCS_DATA_BITS - 5'h01) begin
                    // status is read-only, so only register zero commits
                    commit_r <= (reg_r == `PBCS_REG_CTL);
                    commit_data_r <= {wd_sh_r[14:0], bit_in};
                end
            end
        end
    end

    // serial frame engine, advanced once per management clock rising edge;
    // it only tracks where in the frame the line is, the blocks above act on it
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= PBCS_PRE;
            ones_r <= 6'h00;
            cnt_r <= 5'h00;
        end else begin
            if (mdc_rise) begin
                case (state_r)
                    PBCS_PRE: begin
                        if (bit_in) begin
                            if (ones_r != `PBCS_PREAMBLE_ONES) begin
                                ones_r <= ones_r + 6'h01;
                            end
                        end else begin
                            if (ones_r == `PBCS_PREAMBLE_ONES) begin
                                state_r <= PBCS_START;
                            end
                            ones_r <= 6'h00;
                        end
                    end
                    PBCS_START: begin
                        cnt_r <= 5'h00;
                        state_r <= bit_in ? PBCS_HDR : PBCS_PRE;
                    end
                    // twelve header bits; the capture block keeps their fields
                    PBCS_HDR: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `PBCS_HDR_LAST) begin
                            cnt_r <= 5'h00;
                            // other addresses and opcodes drop back to hunting
                            state_r <= hdr_hit ? PBCS_TA : PBCS_PRE;
                        end
                    end
                    // a read turns the line at once, a write lets both bits pass
                    PBCS_TA: begin
                        if (is_read_r) begin
                            state_r <= PBCS_RDATA;
                        end else if (cnt_r == 5'h01) begin
                            cnt_r <= 5'h00;
                            state_r <= PBCS_WDATA;
                        end else begin
                            cnt_r <= 5'h01;
                        end
                    end
                    // sixteen data bits out, then one more edge to let go of the pin
                    PBCS_RDATA: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `PBCS_DATA_BITS) begin
                            cnt_r <= 5'h00;
                            state_r <= PBCS_PRE;
                        end
                    end
                    // sixteen data bits in
                    PBCS_WDATA: begin
                        cnt_r <= cnt_r + 5'h01;
                        if (cnt_r == `PBCS_DATA_BITS - 5'h01) begin
                            cnt_r <= 5'h00;
                            state_r <= PBCS_PRE;
                        end
                    end
                    default: begin
                        state_r <= PBCS_PRE;
                    end
                endcase
            end
        end
    end

    // control word; a management write beats a mirror write in the same cycle.
    // unsupported bits are masked so they stay zero whatever is written
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_r <= `PBCS_CTL_RST;
        end else if (commit_r) begin
            ctl_r <= commit_data_r & `PBCS_CTL_WMASK;
        end else if (mirror_we) begin
            ctl_r <= mirror_wdata & `PBCS_CTL_WMASK;
        end else begin
            ctl_r.autoneg_restart <= 1'b0; // self-clearing after its pulse
        end
    end

    // one pulse per write of a one to the restart bit
    always_ff @(posedge clk) begin
        if (rst) begin
            autoneg_restart_pulse <= 1'b0;
        end else if (commit_r) begin
            autoneg_restart_pulse <= commit_data_r[`PBCS_CTL_RESTART_BIT];
        end else begin
            autoneg_restart_pulse <= mirror_we & mirror_wdata[`PBCS_CTL_RESTART_BIT];
        end
    end

    // loopback steering: the selected port wraps at its own media attachment
    always_ff @(posedge clk) begin
        if (rst) begin
            loop_port1_on <= 1'b0;
            loop_port2_on <= 1'b0;
        end else begin
            loop_port1_on <= ctl_r.loopback & ~loop_sel_port2;
            loop_port2_on <= ctl_r.loopback & loop_sel_port2;
        end
    end

    // control fields go straight to the port logic from the register
    assign ctl = ctl_r;

endmodule

// ---- sim/pbcs_phy_regs_properties.sv ----
`timescale 1ns/1ps
`include "pbcs_defs.svh"
module pbcs_checker
    import pbcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic mirror_we,
    input wire logic [15:0] mirror_wdata,
    input wire logic loop_sel_port2,
    input wire pbcs_ctl_s ctl,
    input wire logic autoneg_restart_pulse,
    input wire logic loop_port1_on,
    input wire logic loop_port2_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // restart request landing, and a read answer holding the pin for its data bits
    sequence s_restart_set; $rose(ctl.autoneg_restart); endsequence
    sequence s_restart_gone; !ctl.autoneg_restart && !autoneg_restart_pulse; endsequence
    sequence s_read_open; $rose(mdio_oe); endsequence
    sequence s_read_hold; mdio_oe [*8] ##[1:300] !mdio_oe; endsequence
    property p_rst; $fell(rst) |-> ctl == `PBCS_CTL_RST && !mdio_oe && !loop_port1_on; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_rsvd;
        !(ctl.soft_reset || ctl.isolate || ctl.collision_test || ctl.reserved6);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("unsupported control bit set");
    property p_restart; s_restart_set |-> autoneg_restart_pulse ##1 s_restart_gone; endproperty
    a_restart: assert property (p_restart) else $error("restart not pulsed once");
    property p_pulse; autoneg_restart_pulse |-> ctl.autoneg_restart; endproperty
    a_pulse: assert property (p_pulse) else $error("restart pulse without request");
    property p_loop1; ctl.loopback && !loop_sel_port2 |=> loop_port1_on && !loop_port2_on; endproperty
    a_loop1: assert property (p_loop1) else $error("port one wrap wrong");
    property p_loop2; ctl.loopback && loop_sel_port2 |=> loop_port2_on && !loop_port1_on; endproperty
    a_loop2: assert property (p_loop2) else $error("port two wrap wrong");
    property p_turn; s_read_open |-> !mdio_out; endproperty
    a_turn: assert property (p_turn) else $error("turnaround bit not zero");
    property p_oe_len; s_read_open |=> s_read_hold; endproperty
    a_oe_len: assert property (p_oe_len) else $error("read drive window wrong");
    property p_mirror; mirror_we |=> ctl == ($past(mirror_wdata) & `PBCS_CTL_WMASK); endproperty
    a_mirror: assert property (p_mirror) else $error("mirror image not taken");
endmodule

// ---- sim/pbcs_mgmt_station.sv ----
`timescale 1ns/1ps
// management station; the pin has a pull-up, so a released line reads one
module pbcs_mgmt_station (
    input logic clk,
    input logic mdio_out,
    input logic mdio_oe,
    output logic mdc,
    output logic mdio_in
);
    logic ds = 1'b0;
    logic dd = 1'b1;
    assign mdio_in = mdio_oe ? mdio_out : (ds ? dd : 1'b1);
    initial mdc = 1'b0;
    // whole frame; data moves while the clock is low, clock rests low between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic ta0, output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        // one idle cycle first, so the release at the end of a previous frame
        // and the first bit of this one never share a time step
        @(posedge clk);
        #1;
        for (int i = 0; i < 64; i++) begin
            ds = !(op == 2'h2 && i >= 46);
            dd = bits[63 - i];
            repeat (5) @(posedge clk);
            #1;
            if (i == 47) ta0 = mdio_in;
            if (i >= 48) rd = {rd[14:0], mdio_in};
            mdc = 1'b1;
            repeat (5) @(posedge clk);
            #1;
            mdc = 1'b0;
        end
        ds = 1'b0;
    endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import pbcs_pkg::*;
    logic clk, rst, mdc, mdio_in, mdio_out, mdio_oe, phy_addr_load, mirror_we, loop_sel_port2;
    logic link_up, an_done, far_end_fault, autoneg_restart_pulse, loop_port1_on, loop_port2_on;
    logic [4:0] phy_addr_cfg;
    logic [15:0] mirror_wdata, rd;
    pbcs_ctl_s ctl;
    int failures = 0, checks_done = 0, cyc = 0, pulses = 0;
    pbcs_phy_regs dut (.clk(clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .phy_addr_load(phy_addr_load), .phy_addr_cfg(phy_addr_cfg),
        .mirror_we(mirror_we), .mirror_wdata(mirror_wdata), .loop_sel_port2(loop_sel_port2),
        .link_up(link_up), .an_done(an_done), .far_end_fault(far_end_fault), .ctl(ctl),
        .autoneg_restart_pulse(autoneg_restart_pulse), .loop_port1_on(loop_port1_on),
        .loop_port2_on(loop_port2_on));
    pbcs_mgmt_station mst (.clk(clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
        .mdio_in(mdio_in));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, plus a tally of restart pulses so a double pulse shows
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (autoneg_restart_pulse === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // write frame, then room for the synchroniser and the commit
    task automatic mw(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] r;
        logic t;
        mst.frame(2'h1, pa, ra, d, t, r);
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic mr(input logic [4:0] ra, output logic [15:0] r);
        logic t;
        mst.frame(2'h2, 5'h02, ra, 16'h0000, t, r);
        chk({15'h0000, t}, 16'h0000);
    endtask
    task automatic t_defaults();
        chk(ctl, 16'h1020);
        mr(5'h00, rd);
        chk(rd, 16'h1020);
        mr(5'h01, rd);
        chk(rd, 16'h781C);
        mr(5'h05, rd);
        chk(rd, 16'h0000);
    endtask
    task automatic t_write();
        mw(5'h02, 5'h00, 16'hFFFF);
        chk(ctl, 16'h793F);
        chk(pulses[15:0], 16'h0001);
        chk({14'h0000, loop_port1_on, loop_port2_on}, 16'h0002);
        loop_sel_port2 = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0000, loop_port1_on, loop_port2_on}, 16'h0001);
        mw(5'h02, 5'h00, 16'h0000);
        chk(ctl, 16'h0000);
        mr(5'h01, rd);
        chk(rd, 16'h7814);
    endtask
    // refused frames: status register, another management address, illegal opcode
    task automatic t_refuse();
        logic t;
        mw(5'h02, 5'h01, 16'hFFFF);
        mw(5'h01, 5'h00, 16'hFFFF);
        mst.frame(2'h0, 5'h02, 5'h00, 16'hFFFF, t, rd);
        mr(5'h01, rd);
        chk(rd, 16'h7814);
        chk(ctl, 16'h0000);
    endtask
    task automatic t_mirror();
        mirror_wdata = 16'hA5F6;
        mirror_we = 1'b1;
        @(posedge clk);
        #1;
        mirror_we = 1'b0;
        chk(ctl, 16'h2136);
    endtask
    task automatic t_addr();
        phy_addr_cfg = 5'h09;
        phy_addr_load = 1'b1;
        @(posedge clk);
        #1;
        phy_addr_load = 1'b0;
        mw(5'h02, 5'h00, 16'h2000);
        mw(5'h09, 5'h00, 16'h1000);
        chk(ctl, 16'h1000);
    endtask
    initial begin
        rst = 1'b1;
        phy_addr_load = 1'b0;
        phy_addr_cfg = 5'h02;
        mirror_we = 1'b0;
        mirror_wdata = 16'h0000;
        loop_sel_port2 = 1'b0;
        link_up = 1'b1;
        an_done = 1'b0;
        far_end_fault = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        t_defaults();
        t_write();
        t_refuse();
        t_mirror();
        t_addr();
        wrap_up();
    end
endmodule
bind pbcs_phy_regs pbcs_checker chk_i (.clk(clk), .rst(rst), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mirror_we(mirror_we), .mirror_wdata(mirror_wdata),
    .loop_sel_port2(loop_sel_port2), .ctl(ctl), .autoneg_restart_pulse(autoneg_restart_pulse),
    .loop_port1_on(loop_port1_on), .loop_port2_on(loop_port2_on));
